// file: verification/mac_regs_top_bench.sv
// Self-checking bench for the active-configuration register slice.
// Assumes an APB slave that may insert waits and the constants of mac_pkg.
`timescale 1ns/100ps
`default_nettype none
module mac_regs_top_bench
  import mac_pkg::*;
;
  logic        clk, rst, ce, psel, pen, pwr, ev, snap, pready, pslverr, tmode, exp_mode;
  logic [2:0]  state;
  logic [12:0] paddr;
  logic [31:0] pwdata, prdata, fout, tout, seed, v, exp_drive;
  logic [31:0] prog [AV_NUM];
  logic [31:0] act [AV_NUM];
  logic [31:0] exp_av [AV_NUM];
  logic [32:0] q [$];
  int          n_fail, comparisons;

  always #2.5 clk = ~clk;

  mac_regs_top dut_u (
    .MCLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .CTRL_STATE_I(state), .PERF_EVENT_I(ev),
    .PERF_SNAP_I(snap), .FUNC_OUT_I(fout), .TEST_OUT_O(tout), .TEST_MODE_O(tmode),
    .PROG_DRAM_ADDR_I(prog[0]), .PROG_ADDR_DECODE_I(prog[1]), .PROG_SYS_MAP_I(prog[2]),
    .PROG_SLEEP_I(prog[3]), .PROG_RW_RANK_I(prog[4]), .PROG_ROW_HIT_I(prog[5]),
    .PROG_QOS_CLASS_I(prog[6]), .PROG_PRIO_RAISE_I(prog[7]), .PROG_QOS_PRIO_LOW_I(prog[8]),
    .PROG_QOS_PRIO_HIGH_I(prog[9]), .PROG_QOS_TMO_LOW_I(prog[10]),
    .PROG_QOS_TMO_HIGH_I(prog[11]), .PROG_TMO_PRESCALE_I(prog[12]),
    .ACTIVE_DRAM_ADDR_O(act[0]), .ACTIVE_ADDR_DECODE_O(act[1]), .ACTIVE_SYS_MAP_O(act[2]),
    .ACTIVE_SLEEP_O(act[3]), .ACTIVE_RW_RANK_O(act[4]), .ACTIVE_ROW_HIT_O(act[5]),
    .ACTIVE_QOS_CLASS_O(act[6]), .ACTIVE_PRIO_RAISE_O(act[7]),
    .ACTIVE_QOS_PRIO_LOW_O(act[8]), .ACTIVE_QOS_PRIO_HIGH_O(act[9]),
    .ACTIVE_QOS_TMO_LOW_O(act[10]), .ACTIVE_QOS_TMO_HIGH_O(act[11]),
    .ACTIVE_TMO_PRESCALE_O(act[12])
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    comparisons++;
    if (seen !== want) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // One APB transfer, then an idle cycle; a read notes its expected answer.
  task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) q.push_back(e);
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_fail++;
      final_report();
    end
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h000000000);
  endtask : wr

  task automatic rd(input logic [12:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h00000000, e);
  endtask : rd

  // Each completed read is compared with the oldest noted answer.
  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1 && !pwr) begin
      if (q.size() > 0) check({pslverr, prdata}, q.pop_front());
      else n_fail++;
    end
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    {psel, pen, pwr, ev, snap} = 5'h00;
    paddr = 13'h0000;
    pwdata = 32'h00000000;
    state = ST_READY;
    seed = 32'h0001021C;
    n_fail = 0;
    comparisons = 0;
    fout = rnd();
    for (int i = 0; i < AV_NUM; i++) prog[i] = rnd();
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < AV_NUM; i++) begin
      check({1'b0, act[i]}, {1'b0, AV_RST[i]});
      exp_av[i] = AV_RST[i];
      wr(AV_OFS[i], ~AV_RST[i]);
      rd(AV_OFS[i], {1'b0, AV_RST[i]});
    end
    rd(13'h0004, {1'b1, 32'h00000000});
    rd(OFS_TEST_SETUP, 33'h000000000);
    v = rnd();
    wr(OFS_PERF_LOW, v);
    rd(OFS_PERF_LOW, {1'b0, v});
    ev <= 1'b1;
    repeat (3) @(posedge clk);
    ev <= 1'b0;
    snap <= 1'b1;
    @(posedge clk);
    snap <= 1'b0;
    wr(OFS_PERF_SNAP, ~v);
    rd(OFS_PERF_SNAP, {1'b0, v + 32'h00000003});
    rd(OFS_PERF_LOW, {1'b0, v + 32'h00000003});
    exp_mode = 1'b0;
    exp_drive = 32'h00000000;
    for (int s = 3; s >= 0; s--) begin
      state <= 3'(s);
      // The decode word only passes through; its order fields are never decoded here.
      for (int i = 0; i < AV_NUM; i++) prog[i] <= rnd();
      repeat (2) @(posedge clk);
      for (int i = 0; i < AV_NUM; i++) begin
        if (s <= 1 || (s == 2 && AV_HALT_OK[i])) exp_av[i] = prog[i];
        check({1'b0, act[i]}, {1'b0, exp_av[i]});
      end
      rd(AV_OFS[12 - s], {1'b0, exp_av[12 - s]});
      v = rnd();
      wr(OFS_TEST_SETUP, 32'h00000001);
      wr(OFS_TEST_DRIVE, v);
      if (s <= 1) begin
        exp_mode = 1'b1;
        exp_drive = v;
      end
      rd(OFS_TEST_SETUP, {32'h00000000, exp_mode});
      rd(OFS_TEST_DRIVE, 33'h000000000);
      check({32'h00000000, tmode}, {32'h00000000, exp_mode});
      check({1'b0, tout}, {1'b0, exp_mode ? exp_drive : fout});
    end
    ce <= 1'b0;
    for (int i = 0; i < AV_NUM; i++) prog[i] <= rnd();
    repeat (3) @(posedge clk);
    for (int i = 0; i < AV_NUM; i++) check({1'b0, act[i]}, {1'b0, exp_av[i]});
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < AV_NUM; i++) check({1'b0, act[i]}, {1'b0, prog[i]});
    state <= ST_READY;
    wr(OFS_TEST_DRIVE, ~exp_drive);
    @(posedge clk);
    check({1'b0, tout}, {1'b0, exp_drive});
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < AV_NUM; i++) check({1'b0, act[i]}, {1'b0, AV_RST[i]});
    rd(OFS_PERF_LOW, 33'h000000000);
    repeat (2) @(posedge clk);
    if (q.size() != 0) n_fail++;
    final_report();
  end
endmodule : mac_regs_top_bench
`default_nettype wire

// file: verification/mac_regs_top_monitor.sv
// Concurrent checks for the active-configuration register slice.
// Assumes it is bound to mac_regs_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module mac_regs_monitor
  import mac_pkg::*;
(
  // Clock and reset
  input wire logic        MCLK_I,
  input wire logic        SYS_RST_I,
  input wire logic        CE_I,
  // APB
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [12:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  // State and watched words
  input wire logic [2:0]  CTRL_STATE_I,
  input wire logic        TEST_MODE_O,
  input wire logic [31:0] PROG_DRAM_ADDR_I,
  input wire logic [31:0] ACTIVE_DRAM_ADDR_O,
  input wire logic [31:0] PROG_TMO_PRESCALE_I,
  input wire logic [31:0] ACTIVE_TMO_PRESCALE_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  logic st_early;
  logic st_late;
  assign st_early = CE_I && (CTRL_STATE_I inside {ST_SETUP, ST_SLEEP});
  assign st_late  = CE_I && (CTRL_STATE_I inside {ST_SETUP, ST_SLEEP, ST_HALTED});
  sequence s_access;
    PSEL_I && PENABLE_I && CE_I;
  endsequence
  sequence s_test_wr;
    s_access ##0 (PWRITE_I && PADDR_I == OFS_TEST_SETUP);
  endsequence
  sequence s_drive_rd;
    PSEL_I && !PENABLE_I && !PWRITE_I && CE_I && PADDR_I == OFS_TEST_DRIVE;
  endsequence
  a_frozen_no_ce : assert property (!CE_I |=>
    $stable(TEST_MODE_O) && $stable(ACTIVE_TMO_PRESCALE_O))
    else $error("State moved while the clock enable was low.");
  a_dram_loads : assert property (st_early |=> ACTIVE_DRAM_ADDR_O == $past(PROG_DRAM_ADDR_I))
    else $error("Active address word did not load.");
  a_dram_frozen : assert property (!st_early |=> $stable(ACTIVE_DRAM_ADDR_O))
    else $error("Active address word changed while locked.");
  a_scale_loads : assert property (st_late |=> ACTIVE_TMO_PRESCALE_O == $past(PROG_TMO_PRESCALE_I))
    else $error("Prescale word did not load.");
  a_scale_frozen : assert property (!st_late |=> $stable(ACTIVE_TMO_PRESCALE_O))
    else $error("Prescale word changed while locked.");
  a_test_mode_set : assert property (s_test_wr ##0 st_early |=>
    TEST_MODE_O == $past(PWDATA_I[TEST_EN_BIT]))
    else $error("Test mode did not take the written bit.");
  a_test_mode_kept : assert property (s_test_wr ##0 !st_early |=> $stable(TEST_MODE_O))
    else $error("Test mode changed in a locked state.");
  a_drive_reads_zero : assert property (s_drive_rd ##1 s_access |-> PRDATA_O == 32'h00000000)
    else $error("Test drive word was readable.");
  a_ro_no_error : assert property (s_access ##0 (PADDR_I == OFS_PERF_SNAP ||
    PADDR_I == AV_OFS[0]) |-> !PSLVERR_O)
    else $error("Read-only word answered with an error.");
endmodule : mac_regs_monitor

bind mac_regs_top mac_regs_monitor mon_u (
  .MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .CE_I(CE_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .CTRL_STATE_I(CTRL_STATE_I), .TEST_MODE_O(TEST_MODE_O),
  .PROG_DRAM_ADDR_I(PROG_DRAM_ADDR_I), .ACTIVE_DRAM_ADDR_O(ACTIVE_DRAM_ADDR_O),
  .PROG_TMO_PRESCALE_I(PROG_TMO_PRESCALE_I), .ACTIVE_TMO_PRESCALE_O(ACTIVE_TMO_PRESCALE_O)
);
`default_nettype wire

// file: verilog/mac_active_slot.sv
// One read-only active-view word that shadows its programmed value.
// Assumes the parent decides in which controller states loading is allowed.
`timescale 1ns/100ps
`default_nettype none
module mac_active_slot #(
  parameter logic [31:0] RST_VAL = 32'h00000000
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Load control and data
  input  wire logic        load_ok_i,
  input  wire logic [31:0] prog_i,
  output logic      [31:0] value_o
);

  logic [31:0] value_reg;
  logic [31:0] value_next;

  // The active value follows the programmed one only while allowed.
  always_comb begin
    value_next = value_reg;
    if (load_ok_i) begin
      value_next = prog_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      value_reg <= RST_VAL;
    end else if (ce_i) begin
      value_reg <= value_next;
    end
  end

  assign value_o = value_reg;

endmodule : mac_active_slot
`default_nettype wire

// file: verilog/mac_perf_counter.sv
// Performance counter low word with a read-only snapshot.
// Assumes event and snapshot strobes are synchronous one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none
module mac_perf_counter
  import mac_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Software load
  input  wire logic        wr_i,
  input  wire logic [31:0] wdata_i,
  // Events
  input  wire logic        count_i,
  input  wire logic        snap_i,
  // Values
  output logic      [31:0] value_o,
  output logic      [31:0] snap_o
);

  logic [31:0] value_reg;
  logic [31:0] value_next;
  logic [31:0] snap_reg;
  logic [31:0] snap_next;

  // A software write takes priority over a counted event.
  always_comb begin
    value_next = value_reg;
    snap_next  = snap_reg;
    if (wr_i) begin
      value_next = wdata_i;
    end else if (count_i) begin
      value_next = value_reg + 32'h00000001;
    end
    if (snap_i) begin
      snap_next = value_reg;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      value_reg <= RST_PERF_LOW;
      snap_reg  <= RST_PERF_SNAP;
    end else if (ce_i) begin
      value_reg <= value_next;
      snap_reg  <= snap_next;
    end
  end

  assign value_o = value_reg;
  assign snap_o  = snap_reg;

endmodule : mac_perf_counter
`default_nettype wire

// file: verilog/mac_pkg.sv
// Constants shared by the active-configuration register slice.
// Assumes a 32-bit APB with byte addresses that fit in 13 bits.
package mac_pkg;

  // ****************************************************************
  // Bus and controller state encodings
  // ****************************************************************
  localparam int          ADDR_W       = 13;
  localparam int          DATA_W       = 32;
  localparam int          STATE_W      = 3;
  localparam logic [2:0]  ST_SETUP     = 3'h0;
  localparam logic [2:0]  ST_SLEEP     = 3'h1;
  localparam logic [2:0]  ST_HALTED    = 3'h2;
  localparam logic [2:0]  ST_READY     = 3'h3;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [12:0] OFS_PERF_LOW      = 13'h0898;
  localparam logic [12:0] OFS_PERF_SNAP     = 13'h0890;
  localparam logic [12:0] OFS_TEST_SETUP    = 13'h0E00;
  localparam logic [12:0] OFS_TEST_DRIVE    = 13'h0E08;

  // ****************************************************************
  // Resets and fields
  // ****************************************************************
  localparam logic [31:0] RST_PERF_LOW      = 32'h00000000;
  localparam logic [31:0] RST_PERF_SNAP     = 32'h00000000;
  localparam logic [31:0] RST_TEST_SETUP    = 32'h00000000;
  localparam logic [31:0] RST_TEST_DRIVE    = 32'h00000000;
  localparam int          TEST_EN_BIT       = 0;

  // ****************************************************************
  // Active-view registers, in table order
  // ****************************************************************
  localparam int          AV_NUM = 13;
  localparam logic [12:0] AV_OFS [AV_NUM] = '{
    13'h1010, 13'h1014, 13'h101C, 13'h1020, 13'h1028, 13'h102C, 13'h1030,
    13'h1034, 13'h1038, 13'h103C, 13'h1040, 13'h1044, 13'h1048};
  localparam logic [31:0] AV_RST [AV_NUM] = '{
    32'h00030202, 32'h001A3000, 32'h00000000, 32'h00000020, 32'h0F0F0F0F,
    32'h08909FBF, 32'h00000FC8, 32'h00080F03, 32'h76543210, 32'hFEDCBA98,
    32'h00000000, 32'h00000000, 32'h00000001};
  // Bit i set: register i may also load in the halted state.
  localparam logic [12:0] AV_HALT_OK = 13'h1FF8;

endpackage : mac_pkg

// file: verilog/mac_regs_top.sv
// APB slave for the counter, integration test and active-view registers.
// Assumes a synchronous controller state input and programmed values
// supplied by the rest of the register bank.
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Perf counter low word is readable and writable in every state.
// - Counter snapshot word is read-only and never changed by software.
// - Test setup enables integration test mode; writable only in setup or sleep.
// - Test mode drives outputs from test drive word; write-only, setup or sleep.
// - Active DRAM address parameters are read-only, load in setup or sleep.
// - Active address decode setting is read-only, load in setup or sleep.
// - Active system address mapping is read-only, load in setup or sleep.
// - Active low-power settings are read-only, load in setup, sleep, halted.
// - Active turnaround settings are read-only, load in setup, sleep, halted.
// - Active row-hit fairness settings read-only, load in setup, sleep, halted.
// - Active QoS class map is read-only, load in setup, sleep, halted.
// - Active escalation settings read-only, load in setup, sleep, halted.
// - Two QoS priority words, ascending reset, load in setup, sleep, halted.
// - Two QoS timeout words, zero reset, load in setup, sleep, halted.
// - Timeout prescaler resets to one, loads in setup, sleep, halted.
module mac_regs_top
  import mac_pkg::*;
(
  // Clock, enable and reset
  input  wire logic        MCLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        CE_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [12:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Controller state and counter events
  input  wire logic [2:0]  CTRL_STATE_I,
  input  wire logic        PERF_EVENT_I,
  input  wire logic        PERF_SNAP_I,
  // Functional outputs and integration test drive
  input  wire logic [31:0] FUNC_OUT_I,
  output logic      [31:0] TEST_OUT_O,
  output logic             TEST_MODE_O,
  // Programmed configuration words
  input  wire logic [31:0] PROG_DRAM_ADDR_I,
  input  wire logic [31:0] PROG_ADDR_DECODE_I,
  input  wire logic [31:0] PROG_SYS_MAP_I,
  input  wire logic [31:0] PROG_SLEEP_I,
  input  wire logic [31:0] PROG_RW_RANK_I,
  input  wire logic [31:0] PROG_ROW_HIT_I,
  input  wire logic [31:0] PROG_QOS_CLASS_I,
  input  wire logic [31:0] PROG_PRIO_RAISE_I,
  input  wire logic [31:0] PROG_QOS_PRIO_LOW_I,
  input  wire logic [31:0] PROG_QOS_PRIO_HIGH_I,
  input  wire logic [31:0] PROG_QOS_TMO_LOW_I,
  input  wire logic [31:0] PROG_QOS_TMO_HIGH_I,
  input  wire logic [31:0] PROG_TMO_PRESCALE_I,
  // Active configuration words to the controller datapath
  output logic      [31:0] ACTIVE_DRAM_ADDR_O,
  output logic      [31:0] ACTIVE_ADDR_DECODE_O,
  output logic      [31:0] ACTIVE_SYS_MAP_O,
  output logic      [31:0] ACTIVE_SLEEP_O,
  output logic      [31:0] ACTIVE_RW_RANK_O,
  output logic      [31:0] ACTIVE_ROW_HIT_O,
  output logic      [31:0] ACTIVE_QOS_CLASS_O,
  output logic      [31:0] ACTIVE_PRIO_RAISE_O,
  output logic      [31:0] ACTIVE_QOS_PRIO_LOW_O,
  output logic      [31:0] ACTIVE_QOS_PRIO_HIGH_O,
  output logic      [31:0] ACTIVE_QOS_TMO_LOW_O,
  output logic      [31:0] ACTIVE_QOS_TMO_HIGH_O,
  output logic      [31:0] ACTIVE_TMO_PRESCALE_O
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [31:0] prog_word [AV_NUM];
  logic [31:0] av_val    [AV_NUM];
  logic        st_setup_sleep;
  logic        st_halted;
  logic        apb_setup;
  logic        apb_access;
  logic        wr_fire;
  logic        hit_perf;
  logic        hit_snap;
  logic        hit_test_setup;
  logic        hit_test_drive;
  logic        hit_av;
  logic [3:0]  av_idx;
  logic        addr_ok;
  logic        test_wr_ok;
  logic [31:0] perf_val;
  logic [31:0] perf_snap;
  logic [31:0] test_setup_reg;
  logic [31:0] test_setup_next;
  logic [31:0] test_drive_reg;
  logic [31:0] test_drive_next;
  logic [31:0] test_out_reg;
  logic [31:0] test_out_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  // ****************************************************************
  // Controller state qualifiers
  // ****************************************************************
  assign st_setup_sleep = (CTRL_STATE_I == ST_SETUP) || (CTRL_STATE_I == ST_SLEEP);
  assign st_halted      = (CTRL_STATE_I == ST_HALTED);
  assign test_wr_ok     = st_setup_sleep;

  // ****************************************************************
  // APB phases
  // ****************************************************************
  // A clock-enable low stalls the access phase; a read set up while it is low returns the old read data.
  assign PREADY_O   = CE_I;
  assign apb_setup  = PSEL_I && !PENABLE_I;
  assign apb_access = PSEL_I && PENABLE_I;
  assign wr_fire    = apb_access && PWRITE_I && PREADY_O;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  always_comb begin
    hit_perf       = 1'b0;
    hit_snap       = 1'b0;
    hit_test_setup = 1'b0;
    hit_test_drive = 1'b0;
    hit_av         = 1'b0;
    av_idx         = 4'h0;
    if (PADDR_I == OFS_PERF_LOW) begin
      hit_perf = 1'b1;
    end else if (PADDR_I == OFS_PERF_SNAP) begin
      hit_snap = 1'b1;
    end else if (PADDR_I == OFS_TEST_SETUP) begin
      hit_test_setup = 1'b1;
    end else if (PADDR_I == OFS_TEST_DRIVE) begin
      hit_test_drive = 1'b1;
    end else begin
      for (int i = 0; i < AV_NUM; i++) begin
        if (PADDR_I == AV_OFS[i]) begin
          hit_av = 1'b1;
          av_idx = 4'(i);
        end
      end
    end
  end

  assign addr_ok = hit_perf || hit_snap || hit_test_setup || hit_test_drive || hit_av;

  // Unmapped addresses answer with an error; read-only words never do.
  assign PSLVERR_O = apb_access && !addr_ok;

  // ****************************************************************
  // Performance counter
  // ****************************************************************
  mac_perf_counter u_perf (
    .clk_i   (MCLK_I),
    .rst_i   (SYS_RST_I),
    .ce_i    (CE_I),
    .wr_i    (wr_fire && hit_perf),
    .wdata_i (PWDATA_I),
    .count_i (PERF_EVENT_I),
    .snap_i  (PERF_SNAP_I),
    .value_o (perf_val),
    .snap_o  (perf_snap)
  );

  // ****************************************************************
  // Integration test registers
  // ****************************************************************
  always_comb begin
    test_setup_next = test_setup_reg;
    test_drive_next = test_drive_reg;
    if (wr_fire && hit_test_setup && test_wr_ok) begin
      test_setup_next = PWDATA_I;
    end
    if (wr_fire && hit_test_drive && test_wr_ok) begin
      test_drive_next = PWDATA_I;
    end
    test_out_next = FUNC_OUT_I;
    if (test_setup_reg[TEST_EN_BIT]) begin
      test_out_next = test_drive_reg;
    end
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      test_setup_reg <= RST_TEST_SETUP;
      test_drive_reg <= RST_TEST_DRIVE;
      test_out_reg   <= 32'h00000000;
    end else if (CE_I) begin
      test_setup_reg <= test_setup_next;
      test_drive_reg <= test_drive_next;
      test_out_reg   <= test_out_next;
    end
  end

  assign TEST_OUT_O  = test_out_reg;
  assign TEST_MODE_O = test_setup_reg[TEST_EN_BIT];

  // ****************************************************************
  // Active-view registers
  // ****************************************************************
  assign prog_word[0]  = PROG_DRAM_ADDR_I;
  assign prog_word[1]  = PROG_ADDR_DECODE_I;
  assign prog_word[2]  = PROG_SYS_MAP_I;
  assign prog_word[3]  = PROG_SLEEP_I;
  assign prog_word[4]  = PROG_RW_RANK_I;
  assign prog_word[5]  = PROG_ROW_HIT_I;
  assign prog_word[6]  = PROG_QOS_CLASS_I;
  assign prog_word[7]  = PROG_PRIO_RAISE_I;
  assign prog_word[8]  = PROG_QOS_PRIO_LOW_I;
  assign prog_word[9]  = PROG_QOS_PRIO_HIGH_I;
  assign prog_word[10] = PROG_QOS_TMO_LOW_I;
  assign prog_word[11] = PROG_QOS_TMO_HIGH_I;
  assign prog_word[12] = PROG_TMO_PRESCALE_I;

  // Software has no write path into these words at all.
  for (genvar g = 0; g < AV_NUM; g++) begin : g_av
    mac_active_slot #(
      .RST_VAL (AV_RST[g])
    ) u_slot (
      .clk_i     (MCLK_I),
      .rst_i     (SYS_RST_I),
      .ce_i      (CE_I),
      .load_ok_i (st_setup_sleep || (st_halted && AV_HALT_OK[g])),
      .prog_i    (prog_word[g]),
      .value_o   (av_val[g])
    );
  end

  // The decode order fields are used as given; distinct values are assumed.
  assign ACTIVE_DRAM_ADDR_O     = av_val[0];
  assign ACTIVE_ADDR_DECODE_O   = av_val[1];
  assign ACTIVE_SYS_MAP_O       = av_val[2];
  assign ACTIVE_SLEEP_O         = av_val[3];
  assign ACTIVE_RW_RANK_O       = av_val[4];
  assign ACTIVE_ROW_HIT_O       = av_val[5];
  assign ACTIVE_QOS_CLASS_O     = av_val[6];
  assign ACTIVE_PRIO_RAISE_O    = av_val[7];
  assign ACTIVE_QOS_PRIO_LOW_O  = av_val[8];
  assign ACTIVE_QOS_PRIO_HIGH_O = av_val[9];
  assign ACTIVE_QOS_TMO_LOW_O   = av_val[10];
  assign ACTIVE_QOS_TMO_HIGH_O  = av_val[11];
  assign ACTIVE_TMO_PRESCALE_O  = av_val[12];

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Read data is captured in the setup cycle and held for the access.
  always_comb begin
    prdata_next = prdata_reg;
    if (apb_setup && !PWRITE_I) begin
      prdata_next = 32'h00000000;
      if (hit_perf) begin
        prdata_next = perf_val;
      end else if (hit_snap) begin
        prdata_next = perf_snap;
      end else if (hit_test_setup) begin
        prdata_next = test_setup_reg;
      end else if (hit_test_drive) begin
        prdata_next = 32'h00000000;
      end else if (hit_av) begin
        prdata_next = av_val[av_idx];
      end
    end
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      prdata_reg <= 32'h00000000;
    end else if (CE_I) begin
      prdata_reg <= prdata_next;
    end
  end

  assign PRDATA_O = prdata_reg;

endmodule : mac_regs_top
`default_nettype wire
